/* File: design/ust_pkg.sv */
// Constants for the serial port setup and transmit block.
// Assumes a single clk_sys domain and a plain strobe register port.
package ust_pkg;

  // ****************************************
  // Register offsets (byte addresses)
  // ****************************************
  localparam logic [3:0] ADDR_CTRL1  = 4'h0;
  localparam logic [3:0] ADDR_CTRL2  = 4'h4;
  localparam logic [3:0] ADDR_BAUD   = 4'h8;
  localparam logic [3:0] ADDR_STATUS = 4'hc;
  localparam logic [3:0] ADDR_DATA   = 4'h1;

  // ****************************************
  // Field positions
  // ****************************************
  // control_reg_one
  localparam int C1_EN     = 7;
  localparam int C1_WLEN   = 6;
  localparam int C1_PON    = 5;
  localparam int C1_PTYPE  = 4;
  localparam int C1_STOP_COUNT_SELECT  = 3;
  localparam int C1_BRK    = 2;
  localparam int C1_TX9    = 0;
  // control_reg_two
  localparam int C2_TRANSMIT_ENABLE_BIT   = 7;
  localparam int C2_RECEIVE_ENABLE_BIT   = 6;
  localparam int C2_HIGH   = 5;
  localparam int C2_TX_EMPTY_IRQ_ENABLE   = 0;
  // uart_status_reg
  localparam int S_PARITY_FAULT_FLAG    = 7;
  localparam int S_NOISE   = 6;
  localparam int S_FRAMING_FLAG    = 5;
  localparam int S_OVERRUN_FLAG    = 4;
  localparam int S_RECEIVER_IDLE_FLAG   = 3;
  localparam int S_RXAV    = 2;
  localparam int S_TRANSMITTER_IDLE_FLAG   = 1;
  localparam int S_TXE     = 0;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] CTRL1_RST  = 8'h00;
  localparam logic [7:0] CTRL2_RST  = 8'h00;
  localparam logic [7:0] BAUD_RST   = 8'h00;
  localparam logic [7:0] STATUS_RST = 8'h0b;

  // ****************************************
  // Timing
  // ****************************************
  localparam logic [6:0] PRESC_LOW  = 7'h3f;
  localparam logic [6:0] PRESC_HIGH = 7'h0f;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_START = 3'b001,
    ST_DATA  = 3'b011,
    ST_STOP  = 3'b010
  } ust_state_e;

endpackage

/* File: design/ust_top.sv */
// Serial port setup, frame format control and transmit path.
// Assumes a plain strobe register port on clk_sys; rx pin comes from outside.
`timescale 1ns/1ns

module ust_top (
  input  wire logic       clk_sys,
  input  wire logic       rstn,
  input  wire logic [3:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr_stb,
  input  wire logic       rd_stb,
  output logic      [7:0] rdata,
  input  wire logic       rx_pin,
  output logic            tx_out,
  output logic            tx_oe,
  output logic            rx_active,
  output logic            irq
);

  // ****************************************
  // Register file
  // ****************************************
  logic [7:0] ctrl1_reg;
  logic [7:0] ctrl2_reg;
  logic [7:0] baud_divisor_reg;
  logic [7:0] status_reg;
  logic [7:0] rdata_reg;
  logic [7:0] buf_reg;
  logic       stat_seen_reg;
  logic       rx_s1_reg;
  logic       rx_s2_reg;

  wire wr_c1   = wr_stb && (addr == ust_pkg::ADDR_CTRL1);
  wire wr_c2   = wr_stb && (addr == ust_pkg::ADDR_CTRL2);
  wire wr_baud = wr_stb && (addr == ust_pkg::ADDR_BAUD);
  wire wr_data = wr_stb && (addr == ust_pkg::ADDR_DATA);
  wire rd_stat = rd_stb && (addr == ust_pkg::ADDR_STATUS);

  wire port_global_enable  = ctrl1_reg[ust_pkg::C1_EN];
  wire word_length_select  = ctrl1_reg[ust_pkg::C1_WLEN];
  wire parity_on           = ctrl1_reg[ust_pkg::C1_PON];
  wire parity_type_select  = ctrl1_reg[ust_pkg::C1_PTYPE];
  wire stop_count_select   = ctrl1_reg[ust_pkg::C1_STOP_COUNT_SELECT];
  wire break_request       = ctrl1_reg[ust_pkg::C1_BRK];
  wire tx_ninth_bit        = ctrl1_reg[ust_pkg::C1_TX9];
  wire transmit_enable_bit = ctrl2_reg[ust_pkg::C2_TRANSMIT_ENABLE_BIT];
  wire receive_enable_bit  = ctrl2_reg[ust_pkg::C2_RECEIVE_ENABLE_BIT];
  wire tx_empty_irq_enable = ctrl2_reg[ust_pkg::C2_TX_EMPTY_IRQ_ENABLE];
  wire tx_buffer_empty_flag  = status_reg[ust_pkg::S_TXE];
  wire transmitter_idle_flag = status_reg[ust_pkg::S_TRANSMITTER_IDLE_FLAG];

  // ****************************************
  // Baud generator
  // ****************************************
  logic [7:0]  div_cnt_reg;
  logic [6:0]  pre_cnt_reg;
  logic        tick;
  logic        baud_restart;
  wire  [6:0]  pre_top = ctrl2_reg[ust_pkg::C2_HIGH] ? ust_pkg::PRESC_HIGH : ust_pkg::PRESC_LOW;
  wire pre_wrap = (pre_cnt_reg == pre_top);
  assign tick = pre_wrap && (div_cnt_reg == baud_divisor_reg);

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pre_cnt_reg <= 7'h00;
      div_cnt_reg <= 8'h00;
    end else if (!port_global_enable || baud_restart) begin
      pre_cnt_reg <= 7'h00;
      div_cnt_reg <= 8'h00;
    end else if (pre_wrap) begin
      pre_cnt_reg <= 7'h00;
      div_cnt_reg <= tick ? 8'h00 : div_cnt_reg + 8'h01;
    end else begin
      pre_cnt_reg <= pre_cnt_reg + 7'h01;
    end
  end

  // ****************************************
  // Transmitter
  // ****************************************
  ust_pkg::ust_state_e state_reg;
  ust_pkg::ust_state_e state_next;
  logic [8:0] shift_reg;
  logic [3:0] bit_cnt_reg;
  logic       stop2_reg;
  logic       brk_reg;
  logic       buf_full_reg;

  function automatic logic par_bit(input logic [8:0] d, input logic nine, input logic odd);
    par_bit = (^(nine ? d[7:0] : {1'b0, d[6:0]})) ^ odd;
  endfunction

  wire tx_run      = port_global_enable && transmit_enable_bit;
  wire [3:0] nbits = word_length_select ? 4'h9 : 4'h8;
  wire idle_now    = (state_reg == ust_pkg::ST_IDLE);
  wire data_take   = wr_data && tx_buffer_empty_flag && stat_seen_reg;
  // start only with data or a break request, and enable
  wire start_frame = idle_now && tx_run && (buf_full_reg || break_request);
  // full-length start bit, not a stub
  assign baud_restart = start_frame;
  wire last_stop   = (state_reg == ust_pkg::ST_STOP) && tick && (!stop2_reg);
  wire last_data   = (bit_cnt_reg == nbits - 4'h1);

  wire [8:0] buf_reg_ext = {1'b0, buf_reg};
  wire [8:0] frame_word = {word_length_select ?
      (parity_on ? par_bit(buf_reg_ext, 1'b1, parity_type_select) : tx_ninth_bit) : 1'b0,
      (!word_length_select && parity_on) ?
      par_bit(buf_reg_ext, 1'b0, parity_type_select) : buf_reg[7], buf_reg[6:0]};

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ust_pkg::ST_IDLE:  if (start_frame) state_next = ust_pkg::ST_START;
      ust_pkg::ST_START: if (tick) state_next = ust_pkg::ST_DATA;
      ust_pkg::ST_DATA:  if (tick && (brk_reg ? (bit_cnt_reg == 4'hc) : last_data))
        state_next = ust_pkg::ST_STOP;
      ust_pkg::ST_STOP:  if (last_stop) state_next = ust_pkg::ST_IDLE;
      default:           state_next = ust_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state_reg   <= ust_pkg::ST_IDLE;
      shift_reg   <= 9'h000;
      bit_cnt_reg <= 4'h0;
      stop2_reg   <= 1'b0;
      brk_reg     <= 1'b0;
    end else if (!tx_run) begin
      state_reg   <= ust_pkg::ST_IDLE;
      bit_cnt_reg <= 4'h0;
      brk_reg     <= 1'b0;
    end else begin
      state_reg <= state_next;
      if (start_frame) begin
        shift_reg   <= break_request ? 9'h000 : frame_word;
        brk_reg     <= break_request;
        stop2_reg   <= stop_count_select;
        bit_cnt_reg <= 4'h0;
      end else if (tick && state_reg == ust_pkg::ST_DATA) begin
        shift_reg   <= {1'b0, shift_reg[8:1]};
        bit_cnt_reg <= bit_cnt_reg + 4'h1;
      end else if (tick && state_reg == ust_pkg::ST_STOP) begin
        stop2_reg <= 1'b0;
        if (!stop2_reg && brk_reg && break_request) begin
          brk_reg <= 1'b1;
        end
      end
    end
  end

  // ****************************************
  // Buffer and status flags
  // ****************************************
  wire frame_done = last_stop && tx_run;
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      buf_reg       <= 8'h00;
      buf_full_reg  <= 1'b0;
      status_reg    <= ust_pkg::STATUS_RST;
      stat_seen_reg <= 1'b0;
    end else if (!port_global_enable) begin
      buf_full_reg  <= 1'b0;
      status_reg    <= ust_pkg::STATUS_RST;
      stat_seen_reg <= 1'b0;
    end else begin
      if (rd_stat) begin
        stat_seen_reg <= 1'b1;
      end else if (data_take) begin
        stat_seen_reg <= 1'b0;
      end
      if (data_take) begin
        buf_reg      <= wdata;
        buf_full_reg <= 1'b1;
      end else if (start_frame && !break_request) begin
        buf_full_reg <= 1'b0;
      end
      if (start_frame && !break_request) begin
        status_reg[ust_pkg::S_TXE] <= 1'b1;
      end else if (data_take) begin
        status_reg[ust_pkg::S_TXE] <= 1'b0;
      end
      if (frame_done) begin
        status_reg[ust_pkg::S_TRANSMITTER_IDLE_FLAG] <= 1'b1;
      end else if (data_take) begin
        status_reg[ust_pkg::S_TRANSMITTER_IDLE_FLAG] <= 1'b0;
      end
    end
  end

  // ****************************************
  // Control registers
  // ****************************************
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ctrl1_reg        <= ust_pkg::CTRL1_RST;
      ctrl2_reg        <= ust_pkg::CTRL2_RST;
      baud_divisor_reg <= ust_pkg::BAUD_RST;
    end else begin
      if (wr_c1) begin
        ctrl1_reg <= wdata;
      end else if (!port_global_enable) begin
        ctrl1_reg[ust_pkg::C1_BRK] <= 1'b0;
      end
      if (wr_c2 && port_global_enable) begin
        ctrl2_reg <= wdata;
      end else if (!port_global_enable) begin
        ctrl2_reg[ust_pkg::C2_TRANSMIT_ENABLE_BIT] <= 1'b0;
        ctrl2_reg[ust_pkg::C2_RECEIVE_ENABLE_BIT] <= 1'b0;
      end
      if (wr_baud) begin
        baud_divisor_reg <= wdata;
      end
    end
  end

  // ****************************************
  // Read port and pins
  // ****************************************
  wire [7:0] rd_mux = (addr == ust_pkg::ADDR_CTRL1)  ? ctrl1_reg :
                      (addr == ust_pkg::ADDR_CTRL2)  ? ctrl2_reg :
                      (addr == ust_pkg::ADDR_BAUD)   ? baud_divisor_reg :
                      (addr == ust_pkg::ADDR_STATUS) ? status_reg : 8'h00;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rdata_reg <= 8'h00;
      rx_s1_reg <= 1'b1;
      rx_s2_reg <= 1'b1;
    end else begin
      rdata_reg <= rd_stb ? rd_mux : 8'h00;
      rx_s1_reg <= rx_pin;
      rx_s2_reg <= rx_s1_reg;
    end
  end

  assign rdata = rdata_reg;
  assign tx_oe     = tx_run;
  assign rx_active = port_global_enable && receive_enable_bit && rx_s2_reg;
  assign tx_out = (state_reg == ust_pkg::ST_START) ? 1'b0 :
                  (state_reg == ust_pkg::ST_DATA)  ? shift_reg[0] : 1'b1;
  assign irq = tx_empty_irq_enable && tx_buffer_empty_flag && port_global_enable;

  // ****************************************
  // Checks
  // ****************************************
  // idle line high
  idle_high_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (tx_run && state_reg == ust_pkg::ST_IDLE) |-> tx_out)
    else $error("tx not high while idle");
  disable_flags_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    !port_global_enable |=> (status_reg == ust_pkg::STATUS_RST && !buf_full_reg))
    else $error("disable did not reset flags");
  write_block_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (wr_data && !tx_buffer_empty_flag && buf_full_reg) |=> $stable(buf_reg))
    else $error("write overwrote pending data");
  tx_abort_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    !tx_run |-> (!tx_oe ##1 (state_reg == ust_pkg::ST_IDLE)))
    else $error("transmitter not reset on disable");
  start_low_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (state_reg == ust_pkg::ST_START) |-> !tx_out)
    else $error("start bit not low");
  load_empty_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (start_frame && !break_request && port_global_enable) |=> tx_buffer_empty_flag)
    else $error("buffer-empty not set on load");
  frame_idle_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    frame_done |=> transmitter_idle_flag)
    else $error("idle not set at frame end");
  load_idle_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (state_reg == ust_pkg::ST_DATA) |-> !start_frame)
    else $error("load while sending");
  baud_align_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    start_frame |=> (state_reg == ust_pkg::ST_START && pre_cnt_reg == 7'h00 &&
      div_cnt_reg == 8'h00))
    else $error("bit timing not restarted at frame start");
  data_shift_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (tick && tx_run && state_reg == ust_pkg::ST_DATA) |=> (shift_reg == {1'b0, $past(shift_reg[8:1])}))
    else $error("data bits not shifted lsb first");
  pins_released_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    !port_global_enable |-> (!tx_oe && !rx_active))
    else $error("pins held while port disabled");
  irq_gate_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    irq |-> (tx_empty_irq_enable && tx_buffer_empty_flag))
    else $error("interrupt without enable and empty buffer");
  status_gate_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (wr_data && !stat_seen_reg) |=> $stable(buf_reg))
    else $error("data write taken without status access");
  clear_seq_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (data_take && port_global_enable && !frame_done) |=> (!transmitter_idle_flag && !tx_buffer_empty_flag))
    else $error("flags not cleared by status then data write");
  empty_full_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    tx_buffer_empty_flag |-> !buf_full_reg)
    else $error("buffer-empty set while data held");
  two_stop_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (tick && tx_run && stop2_reg && state_reg == ust_pkg::ST_STOP) |=> (state_reg == ust_pkg::ST_STOP))
    else $error("second stop bit skipped");
  ninth_bit_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (start_frame && word_length_select && !parity_on && !break_request) |=> (shift_reg[8] == $past(tx_ninth_bit)))
    else $error("ninth bit not taken from its control bit");
  parity_sum_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (start_frame && parity_on && !break_request) |=> ((^shift_reg) == $past(parity_type_select)))
    else $error("parity of data field wrong");
  baud_hold_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    !port_global_enable |=> (pre_cnt_reg == 7'h00 && div_cnt_reg == 8'h00))
    else $error("bit timing runs while disabled");
  ctrl_keep_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (!port_global_enable && !wr_baud) |=> ($stable(baud_divisor_reg) && !transmit_enable_bit &&
      !receive_enable_bit))
    else $error("disable did not clear enables or lost divisor");

endmodule

/* File: dv/ust_link_model.sv */
// Remote serial transceiver that watches the transmit line.
// Assumes a pull-up on the line while the port releases it.
`timescale 1ns/1ns
module ust_link_model #(
  parameter int BIT_CLKS = 32
) (
  input  wire logic       clk_sys,
  input  wire logic       tx_out,
  input  wire logic       tx_oe,
  input  wire logic [3:0] nbits,
  input  wire logic       two_stop_count_select,
  output logic            rx_pin,
  output logic      [8:0] frame_field,
  output logic            stop_ok,
  output int              frame_count
);
  logic line;
  // Released pin floats to the pull-up level
  assign line = tx_oe ? tx_out : 1'b1;
  initial begin
    rx_pin = 1'b1;
    frame_count = 0;
    frame_field = '0;
    stop_ok = 1'b0;
    forever begin
      @(negedge line);
      repeat (BIT_CLKS / 2) @(negedge clk_sys);
      if (line == 1'b0) begin
        frame_field = '0;
        for (int i = 0; i < nbits; i++) begin
          repeat (BIT_CLKS) @(negedge clk_sys);
          frame_field[i] = line;
        end
        repeat (BIT_CLKS) @(negedge clk_sys);
        stop_ok = line;
        if (two_stop_count_select) begin
          repeat (BIT_CLKS) @(negedge clk_sys);
          stop_ok = stop_ok & line;
        end
        // Count only once the last stop bit has ended
        repeat (BIT_CLKS / 2) @(negedge clk_sys);
        frame_count++;
      end
    end
  end
endmodule

/* File: dv/tb_top.sv */
// Self-checking bench for the serial port transmit block.
// Assumes the link model on the far side of the transmit pin.
`timescale 1ns/1ns
module tb_top;
  logic       clk_sys;
  logic       rstn;
  logic [3:0] addr;
  logic [7:0] wdata;
  logic       wr_stb;
  logic       rd_stb;
  logic [7:0] rdata;
  logic       rx_pin;
  logic       tx_out;
  logic       tx_oe;
  logic       rx_active;
  logic       irq;
  logic [3:0] nb;
  logic       two;
  logic [8:0] field;
  logic       stop_ok;
  int         frame_count;
  int         err_count;
  int         n_compared;
  int unsigned seed_init;
  logic [7:0] v;
  logic [7:0] c1;
  logic [7:0] d;
  int         base;
  logic [7:0] fmts [6] = '{8'h80, 8'ha0, 8'hb8, 8'hc1, 8'he8, 8'hf0};

  ust_top u_dut (.clk_sys(clk_sys), .rstn(rstn), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .rx_pin(rx_pin),
    .tx_out(tx_out), .tx_oe(tx_oe), .rx_active(rx_active), .irq(irq));
  ust_link_model #(.BIT_CLKS(32)) u_link (.clk_sys(clk_sys), .tx_out(tx_out),
    .tx_oe(tx_oe), .nbits(nb), .two_stop_count_select(two), .rx_pin(rx_pin),
    .frame_field(field), .stop_ok(stop_ok), .frame_count(frame_count));

  // ****************************************
  // Helpers
  // ****************************************
  task automatic chk(input string what, input logic [8:0] exp, input logic [8:0] got);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] x);
    @(posedge clk_sys);
    addr <= a; wdata <= x; wr_stb <= 1'b1;
    @(posedge clk_sys);
    wr_stb <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] x);
    @(posedge clk_sys);
    addr <= a; rd_stb <= 1'b1;
    @(posedge clk_sys);
    rd_stb <= 1'b0;
    #1 x = rdata;
  endtask
  // Status access then data write, as the flag clearing needs
  task automatic put(input logic [7:0] x);
    logic [7:0] s;
    rd(ust_pkg::ADDR_STATUS, s);
    wr(ust_pkg::ADDR_DATA, x);
  endtask
  task automatic wait_frames(input int n);
    for (int i = 0; i < 1000 && frame_count < base + n; i++) @(posedge clk_sys);
    if (frame_count < base + n) chk("frame arrival", 9'(base + n), 9'(frame_count));
  endtask
  function automatic logic [8:0] exp_field(input logic [7:0] x, input logic [7:0] c);
    logic [8:0] f;
    f = {c[ust_pkg::C1_TX9], x};
    if (!c[ust_pkg::C1_WLEN]) f[8] = 1'b0;
    if (c[ust_pkg::C1_PON] && c[ust_pkg::C1_WLEN]) f[8] = (^x) ^ c[ust_pkg::C1_PTYPE];
    if (c[ust_pkg::C1_PON] && !c[ust_pkg::C1_WLEN]) f[7] = (^x[6:0]) ^ c[ust_pkg::C1_PTYPE];
    return f;
  endfunction
  task automatic set_fmt(input logic [7:0] c);
    c1 = c;
    nb = c[ust_pkg::C1_WLEN] ? 4'h9 : 4'h8;
    two = c[ust_pkg::C1_STOP_COUNT_SELECT];
    wr(ust_pkg::ADDR_CTRL1, c);
    wr(ust_pkg::ADDR_CTRL2, 8'he1);
  endtask

  // ****************************************
  // Clock, watchdog, sequence
  // ****************************************
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  initial begin
    #600000;
    err_count++;
    tally_and_finish();
  end
  initial begin
    rstn = 1'b0; addr = '0; wdata = '0; wr_stb = 1'b0; rd_stb = 1'b0;
    nb = 4'h8; two = 1'b0; c1 = 8'h80;
    seed_init = $urandom(32'hdb5c);
    repeat (2) @(posedge clk_sys);
    rstn <= 1'b1;
    rd(ust_pkg::ADDR_CTRL1, v); chk("ctrl1 reset", ust_pkg::CTRL1_RST, v);
    rd(ust_pkg::ADDR_STATUS, v); chk("status reset", ust_pkg::STATUS_RST, v);
    rd(4'h2, v); chk("unmapped read", 8'h00, v);
    chk("released tx_oe", 1'b0, tx_oe);
    wr(ust_pkg::ADDR_BAUD, 8'h01);
    set_fmt(8'h80);
    chk("tx_oe enabled", 1'b1, tx_oe);
    chk("rx active", 1'b1, rx_active);
    chk("idle line", 1'b1, tx_out);
    chk("irq empty", 1'b1, irq);
    foreach (fmts[k]) begin
      set_fmt(fmts[k]);
      repeat (3) begin
        d = 8'($urandom());
        base = frame_count;
        put(d);
        wait_frames(1);
        chk("frame field", exp_field(d, c1), field);
        chk("stop bits", 1'b1, stop_ok);
        rd(ust_pkg::ADDR_STATUS, v); chk("idle flags", 2'b11, v[1:0]);
      end
    end
    // Back-to-back: second write held, third one refused
    set_fmt(8'h80);
    base = frame_count;
    put(8'h5a);
    rd(ust_pkg::ADDR_STATUS, v); chk("direct load flags", 2'b01, v[1:0]);
    wr(ust_pkg::ADDR_DATA, 8'hc3);
    rd(ust_pkg::ADDR_STATUS, v); chk("held flags", 2'b00, v[1:0]);
    chk("irq held", 1'b0, irq);
    wr(ust_pkg::ADDR_DATA, 8'h0f);
    wait_frames(1); chk("first frame", 9'h05a, field);
    wait_frames(2); chk("second frame", 9'h0c3, field);
    repeat (500) @(posedge clk_sys);
    chk("no third frame", 9'(base + 2), 9'(frame_count));
    // Disable with a frame active and data held
    put(8'h81);
    put(8'h7e);
    repeat (40) @(posedge clk_sys);
    wr(ust_pkg::ADDR_CTRL1, 8'h00);
    chk("pin released", 1'b0, tx_oe);
    chk("rx released", 1'b0, rx_active);
    rd(ust_pkg::ADDR_STATUS, v); chk("disable status", 8'h0b, v);
    rd(ust_pkg::ADDR_CTRL2, v); chk("disable ctrl2", 8'h21, v);
    rd(ust_pkg::ADDR_BAUD, v); chk("baud kept", 8'h01, v);
    repeat (500) @(posedge clk_sys);
    base = frame_count;
    set_fmt(8'h80);
    repeat (500) @(posedge clk_sys);
    chk("buffer emptied", 9'(base), 9'(frame_count));
    put(8'h3c);
    wait_frames(1); chk("after re-enable", 9'h03c, field);
    // Transmit enable dropped mid-frame
    put(8'ha5);
    repeat (60) @(posedge clk_sys);
    wr(ust_pkg::ADDR_CTRL2, 8'h61);
    chk("tx stopped", 1'b0, tx_oe);
    chk("rx kept", 1'b1, rx_active);
    repeat (500) @(posedge clk_sys);
    base = frame_count;
    set_fmt(8'h80);
    put(8'h96);
    wait_frames(1); chk("after tx restart", 9'h096, field);
    tally_and_finish();
  end
endmodule
